// *** verilog/mcd_monitor_command_decoder.sv ***
// Serial command frame receiver and command code decoder
//
// Overview of operation
// - Decode configuration, cell, auxiliary, status group codes
// - Switch pin group write, read, clear codes
// - 0x019 starts switch pulsing, then poll status
// - Duty group write 0x020, read 0x022
// - Duty/switch group B write 0x01C, read 0x01E
// - Cell conversion base 0x260 with rate, permit, channel
// - Cell open wire base 0x228 adds pull select
// - Cell self test base 0x207, rate and pattern
// - Overlap measure base 0x201, rate and permit
// - Input conversion base 0x460, rate and channel
// - Redundant input conversion base 0x400
// - Input open wire base 0x410 with pull select
// - Input self test base 0x407, rate and pattern
// - Status conversion base 0x468, rate and channel
// - Redundant status conversion base 0x408
// - Status self test base 0x40F, rate and pattern
// - Cell plus inputs base 0x46F, rate and permit
// - Cell plus sum base 0x467, rate and permit
// - Clear cell, aux, status with 0x711-0x713
// - 0x714 reports busy without new conversion
// - 0x715 starts mux diagnostic, then poll status
// - Comm group write 0x721, read 0x722, start 0x723
// - Code in low 11 bits, top five zero
// - Error code over 16 bits checked first
// - Status conversion with channel 5 or 6 ignored
module mcd_monitor_command_decoder
	import mcd_pkg::*;
(
	input wire logic CORE_CLK_IN, // Core clock, 40 MHz
	input wire logic RESET_IN, // Synchronous reset, active high
	input wire logic LINK_SCK_IN, // Serial clock from the host, asynchronous
	input wire logic LINK_CS_N_IN, // Frame select from the host, active low
	input wire logic LINK_SDI_IN, // Serial data from the host, MSB first
	input wire logic CONV_BUSY_IN, // Conversion engine busy, core domain
	output logic LINK_SDO_OUT, // Poll status to the host, low while busy
	output mcd_cmd_t CMD_OUT, // Decoded command and its fields
	output logic CMD_VALID_OUT, // One-cycle pulse, CMD_OUT is new
	output logic CMD_REJECT_OUT // One-cycle pulse, frame failed its checks
);

	////////////////////////////////////////////////////////////////////////////
	// Packet error code over the command bits, one bit at a time

	function automatic logic [14:0] pec_of(input logic [15:0] data);
		logic [14:0] rem;
		logic fb;
		rem = PEC_SEED;
		fb = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			fb = data[i] ^ rem[14];
			rem = {rem[13:0], 1'b0} ^ (fb ? PEC_POLY : 15'h0000);
		end
		return rem;
	endfunction

	// Masked match of a code against a base with variable fields zeroed
	function automatic logic code_match(input logic [10:0] cc, input logic [10:0] mask,
		input logic [10:0] base);
		return (cc & mask) == base;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Fixed codes map one to one onto a command kind

	function automatic mcd_cmd_e fixed_kind(input logic [10:0] cc);
		mcd_cmd_e k;
		k = MCD_NO_OPERATION;
		case (cc)
			CC_WR_CFG_A: k = MCD_WRITE_CONFIG_GROUP_A;
			CC_RD_CFG_A: k = MCD_READ_CONFIG_GROUP_A;
			CC_WR_CFG_B: k = MCD_WRITE_CONFIG_GROUP_B;
			CC_RD_CFG_B: k = MCD_READ_CONFIG_GROUP_B;
			CC_RD_CELL_A: k = MCD_READ_CELL_GROUP_A;
			CC_RD_CELL_B: k = MCD_READ_CELL_GROUP_B;
			CC_RD_CELL_C: k = MCD_READ_CELL_GROUP_C;
			CC_RD_CELL_D: k = MCD_READ_CELL_GROUP_D;
			CC_RD_CELL_E: k = MCD_READ_CELL_GROUP_E;
			CC_RD_CELL_F: k = MCD_READ_CELL_GROUP_F;
			CC_RD_AUX_A: k = MCD_READ_AUX_GROUP_A;
			CC_RD_AUX_B: k = MCD_READ_AUX_GROUP_B;
			CC_RD_AUX_C: k = MCD_READ_AUX_GROUP_C;
			CC_RD_AUX_D: k = MCD_READ_AUX_GROUP_D;
			CC_RD_STAT_A: k = MCD_READ_STATUS_GROUP_A;
			CC_RD_STAT_B: k = MCD_READ_STATUS_GROUP_B;
			CC_WR_SW: k = MCD_WRITE_SWITCH_PIN_GROUP;
			CC_RD_SW: k = MCD_READ_SWITCH_PIN_GROUP;
			CC_CLR_SW: k = MCD_CLEAR_SWITCH_PIN_GROUP;
			CC_ST_SW: k = MCD_START_SWITCH_PIN_PULSING;
			CC_WR_DUTY: k = MCD_WRITE_DUTY_GROUP;
			CC_RD_DUTY: k = MCD_READ_DUTY_GROUP;
			CC_WR_DSB: k = MCD_WRITE_DUTY_SWITCH_GROUP_B;
			CC_RD_DSB: k = MCD_READ_DUTY_SWITCH_GROUP_B;
			CC_CLR_CELL: k = MCD_CLEAR_CELL_GROUPS;
			CC_CLR_AUX: k = MCD_CLEAR_AUX_GROUPS;
			CC_CLR_STAT: k = MCD_CLEAR_STATUS_GROUPS;
			CC_POLL: k = MCD_CONVERSION_POLL;
			CC_MUX_DIAG: k = MCD_MUX_DIAGNOSTIC_START;
			CC_WR_COMM: k = MCD_WRITE_PERIPHERAL_COMM_GROUP;
			CC_RD_COMM: k = MCD_READ_PERIPHERAL_COMM_GROUP;
			CC_ST_COMM: k = MCD_START_PERIPHERAL_TRANSFER;
			default: k = MCD_NO_OPERATION;
		endcase
		return k;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Kinds after which the link answers with poll status until the frame ends

	function automatic logic polls_after(input mcd_cmd_e k);
		logic p;
		p = 1'b0;
		case (k)
			MCD_START_SWITCH_PIN_PULSING: p = 1'b1;
			MCD_CELL_CONVERSION_START: p = 1'b1;
			MCD_CELL_OPEN_WIRE_START: p = 1'b1;
			MCD_CELL_SELF_TEST_START: p = 1'b1;
			MCD_OVERLAP_MEASURE_START: p = 1'b1;
			MCD_INPUT_CONVERSION_START: p = 1'b1;
			MCD_INPUT_REDUNDANT_START: p = 1'b1;
			MCD_INPUT_OPEN_WIRE_START: p = 1'b1;
			MCD_INPUT_SELF_TEST_START: p = 1'b1;
			MCD_STATUS_CONVERSION_START: p = 1'b1;
			MCD_STATUS_REDUNDANT_START: p = 1'b1;
			MCD_STATUS_SELF_TEST_START: p = 1'b1;
			MCD_CELL_PLUS_INPUTS_START: p = 1'b1;
			MCD_CELL_PLUS_SUM_START: p = 1'b1;
			MCD_CONVERSION_POLL: p = 1'b1;
			MCD_MUX_DIAGNOSTIC_START: p = 1'b1;
			default: p = 1'b0;
		endcase
		return p;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Link input synchronisers; the first stage feeds only the second

	logic [2:0] sync1_r;
	logic [2:0] sync2_r;
	logic sck_prev_r;

	always_ff @(posedge CORE_CLK_IN) begin
		if (RESET_IN) begin
			sync1_r <= 3'h7; // Deselected, so no false edge follows reset
			sync2_r <= 3'h7;
			sck_prev_r <= 1'b1;
		end else begin
			sync1_r <= {LINK_CS_N_IN, LINK_SCK_IN, LINK_SDI_IN};
			sync2_r <= sync1_r;
			sck_prev_r <= sync2_r[1];
		end
	end

	// Rising serial clock inside a frame takes one data bit
	logic cs_n_s;
	logic sck_s;
	logic sdi_s;
	logic sck_rise;
	assign cs_n_s = sync2_r[2];
	assign sck_s = sync2_r[1];
	assign sdi_s = sync2_r[0];
	assign sck_rise = sck_s & ~sck_prev_r & ~cs_n_s;

	////////////////////////////////////////////////////////////////////////////
	// Frame shifter: command bytes then error code bytes, MSB first

	logic [31:0] shift_r;
	logic [31:0] shift_nxt;
	logic [5:0] count_r;
	logic [5:0] count_nxt;
	logic done_r;
	logic done_nxt;
	logic counting;

	// Bits past the fourth byte are data for other logic and are not counted
	assign counting = sck_rise & (count_r <= FRAME_LAST);
	assign shift_nxt = counting ? {shift_r[30:0], sdi_s} : shift_r;
	assign count_nxt = cs_n_s ? 6'h00 : (counting ? count_r + 6'h01 : count_r);
	assign done_nxt = counting & (count_r == FRAME_LAST);

	always_ff @(posedge CORE_CLK_IN) begin
		if (RESET_IN) begin
			shift_r <= 32'h0000_0000;
			count_r <= 6'h00;
			done_r <= 1'b0;
		end else begin
			shift_r <= shift_nxt;
			count_r <= count_nxt;
			done_r <= done_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Frame checks

	logic [15:0] cmd_word;
	logic [15:0] pec_word;
	logic [10:0] cc;
	logic format_ok;
	logic pec_ok;

	assign cmd_word = shift_r[31:16];
	assign pec_word = shift_r[15:0];
	assign cc = cmd_word[10:0];
	assign format_ok = cmd_word[15:11] == CMD_HIGH_ZERO;
	assign pec_ok = pec_word == {pec_of(cmd_word), 1'b0};

	////////////////////////////////////////////////////////////////////////////
	// Conversion matches; patterns with fixed low bits win over channel forms

	logic hit_cell_conv;
	logic hit_cell_ow;
	logic hit_cell_st;
	logic hit_overlap;
	logic hit_in_conv;
	logic hit_in_red;
	logic hit_in_ow;
	logic hit_in_st;
	logic hit_stat_conv;
	logic hit_stat_red;
	logic hit_stat_st;
	logic hit_cell_in;
	logic hit_cell_sum;

	assign hit_cell_conv = code_match(cc, MK_CELL_CONV, CC_CELL_CONV);
	assign hit_cell_ow = code_match(cc, MK_CELL_OW, CC_CELL_OW);
	assign hit_cell_st = code_match(cc, MK_TEST, CC_CELL_ST);
	assign hit_overlap = code_match(cc, MK_DCP_ONLY, CC_OVERLAP);
	assign hit_in_conv = code_match(cc, MK_CHAN, CC_IN_CONV);
	assign hit_in_red = code_match(cc, MK_CHAN, CC_IN_RED);
	assign hit_in_ow = code_match(cc, MK_IN_OW, CC_IN_OW);
	assign hit_in_st = code_match(cc, MK_TEST, CC_IN_ST);
	assign hit_stat_conv = code_match(cc, MK_CHAN, CC_STAT_CONV);
	assign hit_stat_red = code_match(cc, MK_CHAN, CC_STAT_RED);
	assign hit_stat_st = code_match(cc, MK_TEST, CC_STAT_ST);
	assign hit_cell_in = code_match(cc, MK_DCP_ONLY, CC_CELL_IN);
	assign hit_cell_sum = code_match(cc, MK_DCP_ONLY, CC_CELL_SUM);

	// Fixed-low-bit forms win; combined cell forms beat self test pattern three
	mcd_cmd_e conv_kind;
	assign conv_kind =
		hit_cell_in ? MCD_CELL_PLUS_INPUTS_START :
		hit_cell_sum ? MCD_CELL_PLUS_SUM_START :
		hit_cell_st ? MCD_CELL_SELF_TEST_START :
		hit_in_st ? MCD_INPUT_SELF_TEST_START :
		hit_stat_st ? MCD_STATUS_SELF_TEST_START :
		hit_overlap ? MCD_OVERLAP_MEASURE_START :
		hit_cell_conv ? MCD_CELL_CONVERSION_START :
		hit_cell_ow ? MCD_CELL_OPEN_WIRE_START :
		hit_in_conv ? MCD_INPUT_CONVERSION_START :
		hit_in_red ? MCD_INPUT_REDUNDANT_START :
		hit_in_ow ? MCD_INPUT_OPEN_WIRE_START :
		hit_stat_conv ? MCD_STATUS_CONVERSION_START :
		hit_stat_red ? MCD_STATUS_REDUNDANT_START :
		MCD_NO_OPERATION;

	// Fixed codes and conversion forms never share a pattern of the top bits
	mcd_cmd_e fix_kind;
	mcd_cmd_e any_kind;
	logic stat_chan_bad;
	mcd_cmd_e final_kind;
	assign fix_kind = fixed_kind(cc);
	assign any_kind = (fix_kind != MCD_NO_OPERATION) ? fix_kind : conv_kind;
	assign stat_chan_bad = (any_kind == MCD_STATUS_CONVERSION_START) &
		(cc[CHAN_HI:0] > STATUS_CHAN_MAX);
	assign final_kind = stat_chan_bad ? MCD_NO_OPERATION : any_kind;

	// Field extraction; fields not carried by a kind read as zero
	mcd_cmd_t dec;
	logic has_dcp;
	logic has_pull;
	logic has_test;
	logic has_chan;
	assign has_dcp = hit_cell_conv | hit_cell_ow | hit_overlap | hit_cell_in | hit_cell_sum;
	assign has_pull = (final_kind == MCD_CELL_OPEN_WIRE_START) |
		(final_kind == MCD_INPUT_OPEN_WIRE_START);
	assign has_test = (final_kind == MCD_CELL_SELF_TEST_START) |
		(final_kind == MCD_INPUT_SELF_TEST_START) |
		(final_kind == MCD_STATUS_SELF_TEST_START);
	assign has_chan = (final_kind == MCD_CELL_CONVERSION_START) |
		(final_kind == MCD_CELL_OPEN_WIRE_START) |
		(final_kind == MCD_INPUT_CONVERSION_START) |
		(final_kind == MCD_INPUT_REDUNDANT_START) |
		(final_kind == MCD_INPUT_OPEN_WIRE_START) |
		(final_kind == MCD_STATUS_CONVERSION_START) |
		(final_kind == MCD_STATUS_REDUNDANT_START);
	assign dec.kind = final_kind;
	assign dec.conversion_rate_field = (conv_kind != MCD_NO_OPERATION) ?
		cc[RATE_HI:RATE_LO] : 2'h0;
	assign dec.discharge_permit_bit = has_dcp & cc[DCP_BIT];
	assign dec.pull_direction_select = has_pull & cc[PULL_BIT];
	assign dec.self_test_pattern_select = has_test ? cc[TEST_HI:TEST_LO] : 2'h0;
	assign dec.channel_select = has_chan ? cc[CHAN_HI:0] : 3'h0;

	////////////////////////////////////////////////////////////////////////////
	// Issue: only a clean, known command leaves the block

	logic accept;
	logic reject;
	assign accept = done_r & format_ok & pec_ok & (final_kind != MCD_NO_OPERATION);
	assign reject = done_r & ~(format_ok & pec_ok);

	mcd_cmd_t cmd_r;
	logic valid_r;
	logic reject_r;

	// Last command is held so downstream logic may sample it late
	always_ff @(posedge CORE_CLK_IN) begin
		if (RESET_IN) begin
			cmd_r <= '0;
			valid_r <= 1'b0;
			reject_r <= 1'b0;
		end else begin
			cmd_r <= accept ? dec : cmd_r;
			valid_r <= accept;
			reject_r <= reject;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Poll answer: after a polling command the data line shows not-busy
	// until the frame ends; the host sees status one core cycle late at most

	logic poll_r;
	logic poll_nxt;
	logic sdo_r;
	assign poll_nxt = cs_n_s ? 1'b0 : (accept & polls_after(final_kind)) | poll_r;

	always_ff @(posedge CORE_CLK_IN) begin
		if (RESET_IN) begin
			poll_r <= 1'b0;
			sdo_r <= 1'b1;
		end else begin
			poll_r <= poll_nxt;
			sdo_r <= poll_r ? ~CONV_BUSY_IN : 1'b1;
		end
	end

	assign CMD_OUT = cmd_r;
	assign CMD_VALID_OUT = valid_r;
	assign CMD_REJECT_OUT = reject_r;
	assign LINK_SDO_OUT = sdo_r;

endmodule

// *** shared/mcd_pkg.sv ***
// Package of command codes, field positions and carrier types for the command decoder
package mcd_pkg;

	// Frame layout
	localparam int unsigned CC_W = 11;
	localparam int unsigned CMD_BITS = 16;
	localparam int unsigned FRAME_BITS = 32;
	localparam logic [5:0] FRAME_LAST = 6'h1f;
	localparam logic [4:0] CMD_HIGH_ZERO = 5'h00;
	localparam logic [14:0] PEC_POLY = 15'h4599;
	localparam logic [14:0] PEC_SEED = 15'h0010;

	// Field positions inside the command code
	localparam int unsigned RATE_HI = 8;
	localparam int unsigned RATE_LO = 7;
	localparam int unsigned PULL_BIT = 6;
	localparam int unsigned TEST_HI = 6;
	localparam int unsigned TEST_LO = 5;
	localparam int unsigned DCP_BIT = 4;
	localparam int unsigned CHAN_HI = 2;
	localparam logic [2:0] STATUS_CHAN_MAX = 3'h4;

	// Fixed register-group access codes
	localparam logic [10:0] CC_WR_CFG_A = 11'h001;
	localparam logic [10:0] CC_RD_CFG_A = 11'h002;
	localparam logic [10:0] CC_WR_CFG_B = 11'h024;
	localparam logic [10:0] CC_RD_CFG_B = 11'h026;
	localparam logic [10:0] CC_RD_CELL_A = 11'h004;
	localparam logic [10:0] CC_RD_CELL_B = 11'h006;
	localparam logic [10:0] CC_RD_CELL_C = 11'h008;
	localparam logic [10:0] CC_RD_CELL_D = 11'h00a;
	localparam logic [10:0] CC_RD_CELL_E = 11'h009;
	localparam logic [10:0] CC_RD_CELL_F = 11'h00b;
	localparam logic [10:0] CC_RD_AUX_A = 11'h00c;
	localparam logic [10:0] CC_RD_AUX_B = 11'h00e;
	localparam logic [10:0] CC_RD_AUX_C = 11'h00d;
	localparam logic [10:0] CC_RD_AUX_D = 11'h00f;
	localparam logic [10:0] CC_RD_STAT_A = 11'h010;
	localparam logic [10:0] CC_RD_STAT_B = 11'h012;
	localparam logic [10:0] CC_WR_SW = 11'h014;
	localparam logic [10:0] CC_RD_SW = 11'h016;
	localparam logic [10:0] CC_CLR_SW = 11'h018;
	localparam logic [10:0] CC_ST_SW = 11'h019;
	localparam logic [10:0] CC_WR_DUTY = 11'h020;
	localparam logic [10:0] CC_RD_DUTY = 11'h022;
	localparam logic [10:0] CC_WR_DSB = 11'h01c;
	localparam logic [10:0] CC_RD_DSB = 11'h01e;
	localparam logic [10:0] CC_CLR_CELL = 11'h711;
	localparam logic [10:0] CC_CLR_AUX = 11'h712;
	localparam logic [10:0] CC_CLR_STAT = 11'h713;
	localparam logic [10:0] CC_POLL = 11'h714;
	localparam logic [10:0] CC_MUX_DIAG = 11'h715;
	localparam logic [10:0] CC_WR_COMM = 11'h721;
	localparam logic [10:0] CC_RD_COMM = 11'h722;
	localparam logic [10:0] CC_ST_COMM = 11'h723;

	// Conversion bases and the masks of their fixed bits
	localparam logic [10:0] CC_CELL_CONV = 11'h260;
	localparam logic [10:0] MK_CELL_CONV = 11'h668;
	localparam logic [10:0] CC_CELL_OW = 11'h228;
	localparam logic [10:0] MK_CELL_OW = 11'h628;
	localparam logic [10:0] CC_CELL_ST = 11'h207;
	localparam logic [10:0] CC_OVERLAP = 11'h201;
	localparam logic [10:0] CC_IN_CONV = 11'h460;
	localparam logic [10:0] CC_IN_RED = 11'h400;
	localparam logic [10:0] CC_IN_OW = 11'h410;
	localparam logic [10:0] MK_IN_OW = 11'h638;
	localparam logic [10:0] CC_IN_ST = 11'h407;
	localparam logic [10:0] CC_STAT_CONV = 11'h468;
	localparam logic [10:0] CC_STAT_RED = 11'h408;
	localparam logic [10:0] CC_STAT_ST = 11'h40f;
	localparam logic [10:0] CC_CELL_IN = 11'h46f;
	localparam logic [10:0] CC_CELL_SUM = 11'h467;
	localparam logic [10:0] MK_TEST = 11'h61f;
	localparam logic [10:0] MK_DCP_ONLY = 11'h66f;
	localparam logic [10:0] MK_CHAN = 11'h678;

	typedef enum logic [5:0] {
		MCD_NO_OPERATION,
		MCD_WRITE_CONFIG_GROUP_A, MCD_WRITE_CONFIG_GROUP_B,
		MCD_READ_CONFIG_GROUP_A, MCD_READ_CONFIG_GROUP_B,
		MCD_READ_CELL_GROUP_A, MCD_READ_CELL_GROUP_B, MCD_READ_CELL_GROUP_C,
		MCD_READ_CELL_GROUP_D, MCD_READ_CELL_GROUP_E, MCD_READ_CELL_GROUP_F,
		MCD_READ_AUX_GROUP_A, MCD_READ_AUX_GROUP_B, MCD_READ_AUX_GROUP_C,
		MCD_READ_AUX_GROUP_D, MCD_READ_STATUS_GROUP_A, MCD_READ_STATUS_GROUP_B,
		MCD_WRITE_SWITCH_PIN_GROUP, MCD_READ_SWITCH_PIN_GROUP,
		MCD_CLEAR_SWITCH_PIN_GROUP, MCD_START_SWITCH_PIN_PULSING,
		MCD_WRITE_DUTY_GROUP, MCD_READ_DUTY_GROUP,
		MCD_WRITE_DUTY_SWITCH_GROUP_B, MCD_READ_DUTY_SWITCH_GROUP_B,
		MCD_CELL_CONVERSION_START, MCD_CELL_OPEN_WIRE_START, MCD_CELL_SELF_TEST_START,
		MCD_OVERLAP_MEASURE_START, MCD_INPUT_CONVERSION_START, MCD_INPUT_REDUNDANT_START,
		MCD_INPUT_OPEN_WIRE_START, MCD_INPUT_SELF_TEST_START,
		MCD_STATUS_CONVERSION_START, MCD_STATUS_REDUNDANT_START,
		MCD_STATUS_SELF_TEST_START, MCD_CELL_PLUS_INPUTS_START, MCD_CELL_PLUS_SUM_START,
		MCD_CLEAR_CELL_GROUPS, MCD_CLEAR_AUX_GROUPS, MCD_CLEAR_STATUS_GROUPS,
		MCD_CONVERSION_POLL, MCD_MUX_DIAGNOSTIC_START,
		MCD_WRITE_PERIPHERAL_COMM_GROUP, MCD_READ_PERIPHERAL_COMM_GROUP,
		MCD_START_PERIPHERAL_TRANSFER
	} mcd_cmd_e;

	typedef struct packed {
		mcd_cmd_e kind;
		logic [1:0] conversion_rate_field;
		logic discharge_permit_bit;
		logic pull_direction_select;
		logic [1:0] self_test_pattern_select;
		logic [2:0] channel_select;
	} mcd_cmd_t;

endpackage

// *** dv/mcd_checker.sv ***
// Concurrent checks on the ports of the command decoder, bound to its top module
module mcd_checker
	import mcd_pkg::*;
(
	input wire logic CORE_CLK_IN, // Core clock
	input wire logic RESET_IN, // Synchronous reset, active high
	input wire logic LINK_SCK_IN, // Serial clock from the host
	input wire logic LINK_CS_N_IN, // Frame select, active low
	input wire logic LINK_SDI_IN, // Serial data from the host
	input wire logic CONV_BUSY_IN, // Conversion engine busy
	input wire logic LINK_SDO_OUT, // Poll status to the host
	input wire mcd_cmd_t CMD_OUT, // Decoded command
	input wire logic CMD_VALID_OUT, // Accept pulse
	input wire logic CMD_REJECT_OUT // Reject pulse
);
	default clocking @(posedge CORE_CLK_IN); endclocking
	default disable iff (RESET_IN);

	////////////////////////////////////////////////////////////////////////////////
	// Kinds that carry fields, and kinds that leave the link polling
	wire is_conv = CMD_OUT.kind inside {[MCD_CELL_CONVERSION_START:MCD_CELL_PLUS_SUM_START]};
	wire is_poll = is_conv || (CMD_OUT.kind == MCD_START_SWITCH_PIN_PULSING) ||
		(CMD_OUT.kind == MCD_CONVERSION_POLL) || (CMD_OUT.kind == MCD_MUX_DIAGNOSTIC_START);

	// Accept of a polling kind while the frame is still selected
	sequence poll_accept;
		CMD_VALID_OUT && is_poll && !LINK_CS_N_IN;
	endsequence
	sequence other_accept;
		CMD_VALID_OUT && !is_poll;
	endsequence

	////////////////////////////////////////////////////////////////////////////////
	a_pulse_exclusive: assert property (!(CMD_VALID_OUT && CMD_REJECT_OUT))
		else $error("accept and reject pulses together");
	a_valid_single: assert property (CMD_VALID_OUT |=> !CMD_VALID_OUT)
		else $error("accept pulse longer than one cycle");
	a_reject_single: assert property (CMD_REJECT_OUT |=> !CMD_REJECT_OUT)
		else $error("reject pulse longer than one cycle");
	a_cmd_holds: assert property (!CMD_VALID_OUT |-> $stable(CMD_OUT))
		else $error("command changed without an accept");
	a_accept_kind: assert property (CMD_VALID_OUT |-> CMD_OUT.kind != MCD_NO_OPERATION)
		else $error("accept pulse with no operation");
	a_fixed_fields: assert property (CMD_VALID_OUT && !is_conv |-> CMD_OUT[8:0] == 9'h000)
		else $error("fixed code carries field values");
	a_status_chan: assert property (CMD_VALID_OUT && CMD_OUT.kind == MCD_STATUS_CONVERSION_START
		|-> CMD_OUT.channel_select <= STATUS_CHAN_MAX)
		else $error("status conversion accepted with a bad channel");
	a_poll_follow: assert property (poll_accept |=> LINK_SDO_OUT == !$past(CONV_BUSY_IN))
		else $error("poll status does not follow busy");
	a_quiet_sdo: assert property (other_accept |=> LINK_SDO_OUT [*4])
		else $error("non-polling command drove the poll line");
	a_sdo_low_busy: assert property (!LINK_SDO_OUT |-> $past(CONV_BUSY_IN))
		else $error("poll line low while not busy");
	a_idle_high: assert property (LINK_CS_N_IN [*5] |-> LINK_SDO_OUT)
		else $error("poll line low outside a frame");
	a_frame_first: assert property (CMD_VALID_OUT || CMD_REJECT_OUT
		|-> !$past(LINK_CS_N_IN, 4))
		else $error("pulse without a selected frame");
endmodule

bind mcd_monitor_command_decoder mcd_checker chk_u (.CORE_CLK_IN, .RESET_IN, .LINK_SCK_IN,
	.LINK_CS_N_IN, .LINK_SDI_IN, .CONV_BUSY_IN, .LINK_SDO_OUT, .CMD_OUT, .CMD_VALID_OUT,
	.CMD_REJECT_OUT);

// *** dv/mcd_host_model.sv ***
// Host controller model that frames command words onto the serial link
module mcd_host_model
	import mcd_pkg::*;
(
	input wire logic CORE_CLK_IN, // Core clock, link edges are timed from it
	output logic LINK_SCK_OUT, // Serial clock, still low outside frames
	output logic LINK_CS_N_OUT, // Frame select, active low
	output logic LINK_SDI_OUT // Serial data, MSB first
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HALF = 4; // Four core cycles per half, a 200 ns link period

	initial begin
		LINK_SCK_OUT = 1'b0;
		LINK_CS_N_OUT = 1'b1;
		LINK_SDI_OUT = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Error code over the sixteen command bits, fed MSB first
	function automatic logic [15:0] pec_of(input logic [15:0] word);
		logic [14:0] rem;
		logic fb;
		rem = PEC_SEED;
		for (int i = 15; i >= 0; i--) begin
			fb = word[i] ^ rem[14];
			rem = {rem[13:0], 1'b0} ^ (fb ? PEC_POLY : 15'h0000);
		end
		return {rem, 1'b0};
	endfunction

	// One frame; keep leaves the select low so the host can watch the poll line
	task automatic send(input logic [15:0] word, input logic corrupt, input logic keep);
		logic [31:0] frame;
		frame = {word, pec_of(word) ^ {14'h0000, corrupt, 1'b0}};
		@(posedge CORE_CLK_IN);
		LINK_CS_N_OUT <= 1'b0;
		repeat (HALF) @(posedge CORE_CLK_IN);
		for (int i = 31; i >= 0; i--) begin
			LINK_SDI_OUT <= frame[i];
			repeat (HALF) @(posedge CORE_CLK_IN);
			LINK_SCK_OUT <= 1'b1;
			repeat (HALF) @(posedge CORE_CLK_IN);
			LINK_SCK_OUT <= 1'b0;
		end
		repeat (2 * HALF) @(posedge CORE_CLK_IN);
		LINK_SDI_OUT <= ~frame[0]; // Released line shows no stale data
		if (!keep)
			LINK_CS_N_OUT <= 1'b1;
		repeat (HALF) @(posedge CORE_CLK_IN);
	endtask

	// Ends a held frame, which also ends polling
	task automatic release_select();
		@(posedge CORE_CLK_IN);
		LINK_CS_N_OUT <= 1'b1;
		repeat (2 * HALF) @(posedge CORE_CLK_IN);
	endtask
endmodule

// *** dv/test_mcd_monitor_command_decoder.sv ***
// Self-checking bench for the command decoder, driven by the host model
module test_mcd_monitor_command_decoder
	import mcd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [10:0] code; mcd_cmd_t exp;} mcd_row_t;
	// Fixed codes in the order of the kind enumeration (kinds 1-24, then 38-45)
	localparam logic [10:0] FIXED [32] = '{11'h001, 11'h024, 11'h002, 11'h026, 11'h004,
		11'h006, 11'h008, 11'h00a, 11'h009, 11'h00b, 11'h00c, 11'h00e, 11'h00d, 11'h00f,
		11'h010, 11'h012, 11'h014, 11'h016, 11'h018, 11'h019, 11'h020, 11'h022, 11'h01c,
		11'h01e, 11'h711, 11'h712, 11'h713, 11'h714, 11'h715, 11'h721, 11'h722, 11'h723};
	// Conversion codes with the fields that they should yield
	localparam mcd_row_t ROWS [13] = '{
		'{11'h375, '{MCD_CELL_CONVERSION_START, 2'h2, 1'b1, 1'b0, 2'h0, 3'h5}},
		'{11'h2ee, '{MCD_CELL_OPEN_WIRE_START, 2'h1, 1'b0, 1'b1, 2'h0, 3'h6}},
		'{11'h3c7, '{MCD_CELL_SELF_TEST_START, 2'h3, 1'b0, 1'b0, 2'h2, 3'h0}},
		'{11'h211, '{MCD_OVERLAP_MEASURE_START, 2'h0, 1'b1, 1'b0, 2'h0, 3'h0}},
		'{11'h564, '{MCD_INPUT_CONVERSION_START, 2'h2, 1'b0, 1'b0, 2'h0, 3'h4}},
		'{11'h483, '{MCD_INPUT_REDUNDANT_START, 2'h1, 1'b0, 1'b0, 2'h0, 3'h3}},
		'{11'h5d2, '{MCD_INPUT_OPEN_WIRE_START, 2'h3, 1'b0, 1'b1, 2'h0, 3'h2}},
		'{11'h427, '{MCD_INPUT_SELF_TEST_START, 2'h0, 1'b0, 1'b0, 2'h1, 3'h0}},
		'{11'h4ec, '{MCD_STATUS_CONVERSION_START, 2'h1, 1'b0, 1'b0, 2'h0, 3'h4}},
		'{11'h509, '{MCD_STATUS_REDUNDANT_START, 2'h2, 1'b0, 1'b0, 2'h0, 3'h1}},
		'{11'h5cf, '{MCD_STATUS_SELF_TEST_START, 2'h3, 1'b0, 1'b0, 2'h2, 3'h0}},
		'{11'h57f, '{MCD_CELL_PLUS_INPUTS_START, 2'h2, 1'b1, 1'b0, 2'h0, 3'h0}},
		'{11'h4e7, '{MCD_CELL_PLUS_SUM_START, 2'h1, 1'b0, 1'b0, 2'h0, 3'h0}}};

	logic clk, rst = 1'b1, busy = 1'b0, busy_auto = 1'b0, busy_man = 1'b0;
	logic sck, cs_n, sdi, sdo, valid, reject;
	mcd_cmd_t cmd;
	int n_fail = 0, num_checks = 0, n_valid = 0, n_rej = 0, cycles = 0;

	////////////////////////////////////////////////////////////////////////////////
	mcd_monitor_command_decoder dut_u (.CORE_CLK_IN(clk), .RESET_IN(rst), .LINK_SCK_IN(sck),
		.LINK_CS_N_IN(cs_n), .LINK_SDI_IN(sdi), .CONV_BUSY_IN(busy), .LINK_SDO_OUT(sdo),
		.CMD_OUT(cmd), .CMD_VALID_OUT(valid), .CMD_REJECT_OUT(reject));
	mcd_host_model host_u (.CORE_CLK_IN(clk), .LINK_SCK_OUT(sck), .LINK_CS_N_OUT(cs_n),
		.LINK_SDI_OUT(sdi));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Pulse counting, a busy pattern for the poll checks, and the hang limit
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (valid === 1'b1)
			n_valid <= n_valid + 1;
		if (reject === 1'b1)
			n_rej <= n_rej + 1;
		busy <= busy_auto ? cycles[2] : busy_man; // Single driver of busy
		if (cycles == 30000) begin
			n_fail++;
			$display("BAD %0t run did not finish", $time);
			test_done();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic ok, input string msg);
		num_checks++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask

	// Sends one frame and compares the number of accept and reject pulses
	task automatic do_frame(input logic [15:0] w, input logic bad, input logic keep,
		input int exp_v, input int exp_r);
		int v0, r0;
		v0 = n_valid;
		r0 = n_rej;
		host_u.send(w, bad, keep);
		chk(n_valid - v0 == exp_v && n_rej - r0 == exp_r, "wrong pulse count");
	endtask

	task automatic test_done();
		$display("Checks %0d, mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		mcd_cmd_t e;
		repeat (10) @(posedge clk);
		chk(cmd === '0 && valid === 1'b0 && reject === 1'b0 && sdo === 1'b1, "reset");
		rst <= 1'b0;
		busy_auto <= 1'b1;
		for (int i = 0; i < 32; i++) begin
			e = '0;
			e.kind = mcd_cmd_e'(6'(i < 24 ? i + 1 : i + 14));
			do_frame({5'h00, FIXED[i]}, 1'b0, 1'b0, 1, 0);
			chk(cmd === e, "fixed code");
		end
		for (int i = 0; i < 13; i++) begin
			do_frame({5'h00, ROWS[i].code}, 1'b0, 1'b0, 1, 0);
			chk(cmd === ROWS[i].exp, "conversion");
		end
		// Refused frames leave the last command in place
		e = cmd;
		do_frame(16'h046d, 1'b0, 1'b0, 0, 0);
		do_frame(16'h0028, 1'b0, 1'b0, 0, 0);
		do_frame(16'h07ff, 1'b0, 1'b0, 0, 0);
		do_frame(16'h0801, 1'b0, 1'b0, 0, 1);
		do_frame(16'h0001, 1'b1, 1'b0, 0, 1);
		chk(cmd === e, "refused frame changed the command");
		// Poll with the select held low, busy under bench control
		busy_auto <= 1'b0;
		busy_man <= 1'b1;
		do_frame(16'h0714, 1'b0, 1'b1, 1, 0);
		repeat (3) @(posedge clk);
		chk(sdo === 1'b0, "poll while busy");
		busy_man <= 1'b0;
		repeat (3) @(posedge clk);
		chk(sdo === 1'b1, "poll after done");
		busy_man <= 1'b1;
		host_u.release_select();
		chk(sdo === 1'b1, "poll line after select rose");
		// Second reset in mid-run, then one frame to show recovery
		rst <= 1'b1;
		repeat (10) @(posedge clk);
		chk(cmd === '0 && sdo === 1'b1 && valid === 1'b0, "mid-run reset");
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		do_frame(16'h0019, 1'b0, 1'b1, 1, 0);
		repeat (3) @(posedge clk);
		chk(cmd.kind === MCD_START_SWITCH_PIN_PULSING && sdo === 1'b0, "pulsing poll");
		host_u.release_select();
		test_done();
	end
endmodule
